// >>> rtl/lpws_pkg.sv
/*
 * Constants and types for the low power wake sequencer.
 * Assumes a single 100 MHz system clock; the cycle counts derive from it, OST_EDGE_CNT counts oscillator edges.
 */
package lpws_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int PREP_US = 10;
	localparam int PREP_CYC = (PREP_US * 1000 + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int PLL_LOCK_MS = 2;
	localparam int PLL_LOCK_CYC = PLL_LOCK_MS * 1000000 / CLK_PERIOD_NS;
	localparam int IOS_STAB_MS = 1;
	localparam int IOS_STAB_CYC = IOS_STAB_MS * 1000000 / CLK_PERIOD_NS;
	localparam int OST_EDGE_CNT = 1024;
	localparam int PREP_W = $clog2(PREP_CYC + 1);

	// ************************************************************
	// Register layouts
	// ************************************************************
	localparam int GIE_BIT = 7;
	localparam int IFS_LSB = 4;
	localparam int IFS_W = 3;
	localparam int OSC_CTRL_W = 8;
	localparam logic [OSC_CTRL_W-1:0] OSC_CTRL_RST = 8'h00;
	localparam int TUNE_W = 6;
	localparam logic [TUNE_W-1:0] TUNE_RST = 6'h00;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		PRI_LOW_POWER_CRYSTAL,
		PRI_STANDARD_CRYSTAL,
		PRI_HIGH_SPEED_CRYSTAL,
		PRI_CRYSTAL_PLL_MODE,
		PRI_EXTERNAL_CLOCK_MODE,
		PRI_RESISTOR_CAPACITOR_OSC,
		PRI_FAST_INTERNAL_OSC,
		PRI_SLOW_INTERNAL_RC
	} lpws_pri_t;

	typedef enum logic [1:0] {
		CLK_PRIMARY,
		CLK_SECONDARY_OSC,
		CLK_INTERNAL,
		CLK_NONE
	} lpws_clk_t;

endpackage

// >>> rtl/lpws_wake_seq.sv
/*
 * Wake sequencer for sleep and idle modes: wake sources, start-up waits,
 * clock ready flags, clock hand-back and watchdog clear/reset decisions.
 * Assumes interrupt flags, watchdog time-out, reset request, clock loss
 * and the primary oscillator pin are asynchronous; all else is on clk_i.
 */
`timescale 1ns/10ps
module lpws_wake_seq #(
	parameter int IRQ_N = 8,
	parameter int OST_EDGES = lpws_pkg::OST_EDGE_CNT,
	parameter int PLL_CYC = lpws_pkg::PLL_LOCK_CYC,
	parameter int IOS_CYC = lpws_pkg::IOS_STAB_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Configuration
	input wire lpws_pkg::lpws_pri_t primary_mode_i,
	input wire logic dual_speed_startup_i,
	input wire logic clock_fail_monitor_i,
	// CPU side
	input wire logic sleep_instr_i,
	input wire logic idle_en_i,
	input wire logic watchdog_clear_instruction_i,
	input wire logic [7:0] interrupt_control_reg_i,
	input wire logic osc_ctrl_wr_i,
	input wire logic [lpws_pkg::OSC_CTRL_W-1:0] osc_ctrl_wdata_i,
	input wire logic osc_tune_wr_i,
	input wire logic [lpws_pkg::TUNE_W-1:0] osc_tune_wdata_i,
	// Interrupt logic
	input wire logic [IRQ_N-1:0] irq_flag_i,
	input wire logic [IRQ_N-1:0] irq_enable_i,
	// Asynchronous events and oscillator pin
	input wire logic wdt_timeout_i,
	input wire logic reset_req_i,
	input wire logic clock_loss_i,
	input wire logic primary_osc_i,
	// Execution control
	output logic cpu_run_o,
	output logic cpu_reset_hold_o,
	output logic wake_vector_o,
	output logic wake_resume_o,
	// Clock control and status
	output lpws_pkg::lpws_clk_t sys_clk_sel_o,
	output logic primary_osc_en_o,
	output logic primary_clock_ready_flag_o,
	output logic internal_osc_stable_flag_o,
	output logic [lpws_pkg::OSC_CTRL_W-1:0] oscillator_control_reg_o,
	output logic [lpws_pkg::TUNE_W-1:0] fast_osc_trim_o,
	output logic [lpws_pkg::TUNE_W-1:0] slow_rc_trim_o,
	// Watchdog control
	output logic wdt_clear_o,
	output logic wdt_reset_o
);

	// ************************************************************
	// Parameter checks and widths
	// ************************************************************
	localparam int SW = IRQ_N + 4;
	localparam int PMAX = (PLL_CYC > OST_EDGES) ? PLL_CYC : OST_EDGES;
	localparam int PCW = $clog2(PMAX + 1);
	localparam int ICW = $clog2(IOS_CYC + 1);

	if (IRQ_N < 1 || OST_EDGES < 1 || PLL_CYC < 1 || IOS_CYC < 1) begin : g_bad
		$error("lpws_wake_seq: counts and IRQ_N must be at least one");
	end

	typedef enum logic [1:0] {
		ST_RST_HOLD,
		ST_RUN,
		ST_HALT,
		ST_WAKE
	} lpws_state_t;

	function automatic logic is_crystal(input lpws_pkg::lpws_pri_t m);
		is_crystal = (m == lpws_pkg::PRI_LOW_POWER_CRYSTAL) ||
			(m == lpws_pkg::PRI_STANDARD_CRYSTAL) ||
			(m == lpws_pkg::PRI_HIGH_SPEED_CRYSTAL) ||
			(m == lpws_pkg::PRI_CRYSTAL_PLL_MODE);
	endfunction

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic [SW-1:0] as_raw;
	logic [SW-1:0] s1_r, s2_r, s3_r, flt_r, flt_nxt;

	assign as_raw = {primary_osc_i, clock_loss_i, reset_req_i, wdt_timeout_i,
		irq_flag_i};

	// Filtered level moves only when stages two and three agree
	always_comb begin
		flt_nxt = (s2_r & s3_r) | (flt_r & (s2_r | s3_r));
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			flt_r <= '0;
		end else begin
			s1_r <= as_raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			flt_r <= flt_nxt;
		end
	end

	logic [IRQ_N-1:0] irq_s;
	logic wdt_s, rreq_s, loss_s, osc_s;
	assign irq_s = flt_r[IRQ_N-1:0];
	assign wdt_s = flt_r[IRQ_N];
	assign rreq_s = flt_r[IRQ_N+1];
	assign loss_s = flt_r[IRQ_N+2];
	assign osc_s = flt_r[IRQ_N+3];

	// ************************************************************
	// Sequencer state
	// ************************************************************
	lpws_state_t state_r, state_nxt;
	lpws_pkg::lpws_clk_t sel_r, sel_nxt, halt_clk_r, halt_clk_nxt;
	logic halt_idle_r, halt_idle_nxt, irq_wake_r, irq_wake_nxt;
	logic pri_on_r, pri_on_nxt, pri_rdy_r, pri_rdy_nxt;
	logic pll_ph_r, pll_ph_nxt, sw_pend_r, sw_pend_nxt;
	logic ios_on_r, ios_on_nxt, internal_osc_stable_flag_r, internal_osc_stable_flag_nxt;
	logic [PCW-1:0] pri_cnt_r, pri_cnt_nxt;
	logic [ICW-1:0] ios_cnt_r, ios_cnt_nxt;
	logic [lpws_pkg::PREP_W-1:0] prep_cnt_r, prep_cnt_nxt;
	logic run_r, run_nxt, hold_r, hold_nxt;
	logic vec_r, vec_nxt, res_r, res_nxt, wclr_r, wclr_nxt, wrst_r, wrst_nxt;
	logic [lpws_pkg::OSC_CTRL_W-1:0] octl_r, octl_nxt;
	logic [lpws_pkg::TUNE_W-1:0] ftrim_r, strim_r, trim_nxt;
	logic osc_prev_r, wdt_prev_r;

	logic osc_edge, wdt_edge, wake_req, two_speed, prep_done, fast_pri;
	logic [lpws_pkg::IFS_W-1:0] ifs_old, ifs_new;

	always_comb begin
		osc_edge = osc_s & ~osc_prev_r;
		wdt_edge = wdt_s & ~wdt_prev_r;
		two_speed = dual_speed_startup_i | clock_fail_monitor_i;
		fast_pri = (primary_mode_i == lpws_pkg::PRI_FAST_INTERNAL_OSC);
		prep_done = (prep_cnt_r ==
			lpws_pkg::PREP_W'(lpws_pkg::PREP_CYC - 1));
		wake_req = (|(irq_s & irq_enable_i)) | wdt_edge;
		ifs_old = octl_r[lpws_pkg::IFS_LSB +: lpws_pkg::IFS_W];
		ifs_new = osc_ctrl_wdata_i[lpws_pkg::IFS_LSB +: lpws_pkg::IFS_W];

		state_nxt = state_r;
		sel_nxt = sel_r;
		halt_clk_nxt = halt_clk_r;
		halt_idle_nxt = halt_idle_r;
		irq_wake_nxt = irq_wake_r;
		pri_on_nxt = pri_on_r;
		pri_rdy_nxt = pri_rdy_r;
		pll_ph_nxt = pll_ph_r;
		sw_pend_nxt = sw_pend_r;
		ios_on_nxt = ios_on_r;
		internal_osc_stable_flag_nxt = internal_osc_stable_flag_r;
		pri_cnt_nxt = pri_cnt_r;
		ios_cnt_nxt = ios_cnt_r;
		prep_cnt_nxt = prep_cnt_r;
		run_nxt = run_r;
		hold_nxt = hold_r;
		vec_nxt = 1'b0;
		res_nxt = 1'b0;
		wrst_nxt = 1'b0;
		octl_nxt = octl_r;
		trim_nxt = ftrim_r;

		// Primary start-up: crystal count, then PLL lock time
		if (pri_on_r && !pri_rdy_r) begin
			if (!pll_ph_r) begin
				if (osc_edge) begin
					pri_cnt_nxt = pri_cnt_r + PCW'(1);
					if (pri_cnt_r == PCW'(OST_EDGES - 1)) begin
						pri_cnt_nxt = '0;
						if (primary_mode_i == lpws_pkg::PRI_CRYSTAL_PLL_MODE) begin
							pll_ph_nxt = 1'b1;
						end else begin
							pri_rdy_nxt = 1'b1;
						end
					end
				end
			end else begin
				pri_cnt_nxt = pri_cnt_r + PCW'(1);
				if (pri_cnt_r == PCW'(PLL_CYC - 1)) begin
					pri_rdy_nxt = 1'b1;
				end
			end
		end

		// Fast internal oscillator stabilisation; clocks keep running
		if (ios_on_r) begin
			ios_cnt_nxt = ios_cnt_r + ICW'(1);
			if (ios_cnt_r == ICW'(IOS_CYC - 1)) begin
				ios_on_nxt = 1'b0;
				internal_osc_stable_flag_nxt = 1'b1;
			end
		end

		// Hand back to primary once it is ready
		if (sw_pend_r && pri_rdy_nxt && state_r != ST_HALT) begin
			sw_pend_nxt = 1'b0;
			sel_nxt = lpws_pkg::CLK_PRIMARY;
			if (!fast_pri) begin
				internal_osc_stable_flag_nxt = 1'b0;
				ios_on_nxt = 1'b0;
			end
		end

		if (osc_tune_wr_i) begin
			trim_nxt = osc_tune_wdata_i;
		end

		if (osc_ctrl_wr_i) begin
			octl_nxt = osc_ctrl_wdata_i;
			if (ifs_new == '0) begin
				internal_osc_stable_flag_nxt = 1'b0;
				ios_on_nxt = 1'b0;
			end else if (ifs_old == '0) begin
				ios_on_nxt = 1'b1;
				ios_cnt_nxt = '0;
			end
		end

		case (state_r)
			ST_RST_HOLD: begin
				run_nxt = 1'b0;
				hold_nxt = 1'b1;
				if (!rreq_s) begin
					if (pri_rdy_nxt) begin
						state_nxt = ST_RUN;
						hold_nxt = 1'b0;
						run_nxt = 1'b1;
						sel_nxt = lpws_pkg::CLK_PRIMARY;
						sw_pend_nxt = 1'b0;
					end else if (two_speed) begin
						state_nxt = ST_RUN;
						hold_nxt = 1'b0;
						run_nxt = 1'b1;
						sel_nxt = lpws_pkg::CLK_INTERNAL;
						sw_pend_nxt = 1'b1;
					end
				end
			end
			ST_RUN: begin
				if (wdt_edge) begin
					wrst_nxt = 1'b1;
				end else if (sleep_instr_i) begin
					state_nxt = ST_HALT;
					run_nxt = 1'b0;
					halt_idle_nxt = idle_en_i;
					halt_clk_nxt = idle_en_i ? sel_r : lpws_pkg::CLK_NONE;
					sel_nxt = idle_en_i ? sel_r : lpws_pkg::CLK_NONE;
					if (!(idle_en_i && sel_r == lpws_pkg::CLK_PRIMARY &&
						pri_rdy_r)) begin
						pri_on_nxt = 1'b0;
						pri_rdy_nxt = 1'b0;
						sw_pend_nxt = 1'b0;
					end
					if (!idle_en_i) begin
						internal_osc_stable_flag_nxt = 1'b0;
						ios_on_nxt = 1'b0;
					end
				end
			end
			ST_HALT: begin
				if (wake_req) begin
					state_nxt = ST_WAKE;
					irq_wake_nxt = ~wdt_edge;
					prep_cnt_nxt = '0;
					if (!pri_on_r) begin
						pri_on_nxt = 1'b1;
						sw_pend_nxt = 1'b1;
						pri_cnt_nxt = '0;
						pll_ph_nxt = 1'b0;
						pri_rdy_nxt = ~is_crystal(primary_mode_i);
						if (fast_pri && !(halt_clk_r ==
							lpws_pkg::CLK_INTERNAL && internal_osc_stable_flag_r)) begin
							ios_on_nxt = 1'b1;
							ios_cnt_nxt = '0;
						end
					end
					if (!halt_idle_r) begin
						sel_nxt = two_speed ? lpws_pkg::CLK_INTERNAL :
							lpws_pkg::CLK_NONE;
					end
				end
			end
			ST_WAKE: begin
				if (!prep_done) begin
					prep_cnt_nxt = prep_cnt_r + lpws_pkg::PREP_W'(1);
				end else if (pri_rdy_r || halt_idle_r || two_speed) begin
					state_nxt = ST_RUN;
					run_nxt = 1'b1;
					if (irq_wake_r &&
						interrupt_control_reg_i[lpws_pkg::GIE_BIT]) begin
						vec_nxt = 1'b1;
					end else begin
						res_nxt = 1'b1;
					end
				end
			end
			default: begin
				state_nxt = ST_RST_HOLD;
			end
		endcase

		// Any reset, including the watchdog one, restarts the primary
		if (rreq_s || wrst_nxt) begin
			state_nxt = ST_RST_HOLD;
			run_nxt = 1'b0;
			hold_nxt = 1'b1;
			vec_nxt = 1'b0;
			res_nxt = 1'b0;
			octl_nxt = lpws_pkg::OSC_CTRL_RST;
			internal_osc_stable_flag_nxt = 1'b0;
			ios_on_nxt = 1'b0;
			// Only on entry, so a primary that gets ready while held switches
			if (state_r != ST_RST_HOLD) begin
				sel_nxt = lpws_pkg::CLK_INTERNAL;
				sw_pend_nxt = 1'b1;
				pri_on_nxt = 1'b1;
				pri_cnt_nxt = '0;
				pll_ph_nxt = 1'b0;
				pri_rdy_nxt = ~is_crystal(primary_mode_i);
			end
		end

		wclr_nxt = (state_r == ST_RUN && sleep_instr_i) |
			watchdog_clear_instruction_i |
			(loss_s & clock_fail_monitor_i) |
			(osc_ctrl_wr_i && ifs_new != ifs_old &&
			sel_r == lpws_pkg::CLK_INTERNAL);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= ST_RST_HOLD;
			sel_r <= lpws_pkg::CLK_INTERNAL;
			halt_clk_r <= lpws_pkg::CLK_NONE;
			halt_idle_r <= 1'b0;
			irq_wake_r <= 1'b0;
			pri_on_r <= 1'b1;
			pri_rdy_r <= 1'b0;
			pll_ph_r <= 1'b0;
			sw_pend_r <= 1'b1;
			ios_on_r <= 1'b0;
			internal_osc_stable_flag_r <= 1'b0;
			pri_cnt_r <= '0;
			ios_cnt_r <= '0;
			prep_cnt_r <= '0;
			run_r <= 1'b0;
			hold_r <= 1'b1;
			vec_r <= 1'b0;
			res_r <= 1'b0;
			wclr_r <= 1'b0;
			wrst_r <= 1'b0;
			octl_r <= lpws_pkg::OSC_CTRL_RST;
			ftrim_r <= lpws_pkg::TUNE_RST;
			strim_r <= lpws_pkg::TUNE_RST;
			osc_prev_r <= 1'b0;
			wdt_prev_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sel_r <= sel_nxt;
			halt_clk_r <= halt_clk_nxt;
			halt_idle_r <= halt_idle_nxt;
			irq_wake_r <= irq_wake_nxt;
			pri_on_r <= pri_on_nxt;
			pri_rdy_r <= pri_rdy_nxt;
			pll_ph_r <= pll_ph_nxt;
			sw_pend_r <= sw_pend_nxt;
			ios_on_r <= ios_on_nxt;
			internal_osc_stable_flag_r <= internal_osc_stable_flag_nxt;
			pri_cnt_r <= pri_cnt_nxt;
			ios_cnt_r <= ios_cnt_nxt;
			prep_cnt_r <= prep_cnt_nxt;
			run_r <= run_nxt;
			hold_r <= hold_nxt;
			vec_r <= vec_nxt;
			res_r <= res_nxt;
			wclr_r <= wclr_nxt;
			wrst_r <= wrst_nxt;
			octl_r <= octl_nxt;
			ftrim_r <= trim_nxt;
			strim_r <= trim_nxt;
			osc_prev_r <= osc_s;
			wdt_prev_r <= wdt_s;
		end
	end

	// ************************************************************
	// Outputs, all straight from flops
	// ************************************************************
	assign cpu_run_o = run_r;
	assign cpu_reset_hold_o = hold_r;
	assign wake_vector_o = vec_r;
	assign wake_resume_o = res_r;
	assign sys_clk_sel_o = sel_r;
	assign primary_osc_en_o = pri_on_r;
	assign primary_clock_ready_flag_o = pri_rdy_r;
	assign internal_osc_stable_flag_o = internal_osc_stable_flag_r;
	assign oscillator_control_reg_o = octl_r;
	assign fast_osc_trim_o = ftrim_r;
	assign slow_rc_trim_o = strim_r;
	assign wdt_clear_o = wclr_r;
	assign wdt_reset_o = wrst_r;

endmodule

// >>> testbench/lpws_checker.sv
/*
 * Concurrent checks on the wake sequencer top-level ports.
 * Assumes it is bound to lpws_wake_seq and clocked by its clk_i.
 */
`timescale 1ns/10ps
module lpws_checker (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Watched inputs
	input wire lpws_pkg::lpws_pri_t primary_mode_i,
	input wire logic dual_speed_startup_i,
	input wire logic clock_fail_monitor_i,
	input wire logic sleep_instr_i,
	input wire logic watchdog_clear_instruction_i,
	input wire logic [7:0] interrupt_control_reg_i,
	input wire logic osc_ctrl_wr_i,
	input wire logic [7:0] osc_ctrl_wdata_i,
	input wire logic osc_tune_wr_i,
	input wire logic [5:0] osc_tune_wdata_i,
	// Watched outputs
	input wire logic cpu_run_o,
	input wire logic cpu_reset_hold_o,
	input wire logic wake_vector_o,
	input wire logic wake_resume_o,
	input wire lpws_pkg::lpws_clk_t sys_clk_sel_o,
	input wire logic primary_osc_en_o,
	input wire logic primary_clock_ready_flag_o,
	input wire logic internal_osc_stable_flag_o,
	input wire logic [7:0] oscillator_control_reg_o,
	input wire logic [5:0] fast_osc_trim_o,
	input wire logic [5:0] slow_rc_trim_o,
	input wire logic wdt_clear_o,
	input wire logic wdt_reset_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Halted cycles, saturating so a long sleep cannot wrap
	logic [11:0] halt_cnt_r, halt_cnt_nxt;
	always_comb begin
		halt_cnt_nxt = halt_cnt_r;
		if (cpu_run_o)
			halt_cnt_nxt = 12'h000;
		else if (halt_cnt_r != 12'hfff)
			halt_cnt_nxt = halt_cnt_r + 12'h001;
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			halt_cnt_r <= 12'h000;
		else
			halt_cnt_r <= halt_cnt_nxt;
	end
	sequence s_sleep_taken;
		sleep_instr_i && cpu_run_o;
	endsequence
	sequence s_wake_pulse;
		wake_vector_o || wake_resume_o;
	endsequence
	property p_halt;
		s_sleep_taken |=> !cpu_run_o && (wdt_clear_o || wdt_reset_o);
	endproperty
	a_halt: assert property (p_halt) else $error("sleep not halting");
	property p_power_off;
		s_sleep_taken ##0 !primary_clock_ready_flag_o |-> ##[1:2] !primary_osc_en_o;
	endproperty
	a_power_off: assert property (p_power_off) else $error("primary kept on");
	property p_vec_gie;
		wake_vector_o |-> interrupt_control_reg_i[lpws_pkg::GIE_BIT];
	endproperty
	a_vec_gie: assert property (p_vec_gie) else $error("vector without gie");
	property p_one_kind;
		s_wake_pulse |-> cpu_run_o && !(wake_vector_o && wake_resume_o)
			##1 !(wake_vector_o || wake_resume_o);
	endproperty
	a_one_kind: assert property (p_one_kind) else $error("bad restart pulse");
	property p_prep;
		s_wake_pulse |-> halt_cnt_r >= 12'h3e7;
	endproperty
	a_prep: assert property (p_prep) else $error("restart too early");
	property p_ready_first;
		$rose(cpu_run_o) && $past(cpu_reset_hold_o) && !dual_speed_startup_i
			&& !clock_fail_monitor_i |-> primary_clock_ready_flag_o;
	endproperty
	a_ready_first: assert property (p_ready_first) else $error("ran before ready");
	property p_switch;
		$rose(primary_clock_ready_flag_o)
			&& primary_mode_i != lpws_pkg::PRI_FAST_INTERNAL_OSC |-> ##[0:2]
			(sys_clk_sel_o == lpws_pkg::CLK_PRIMARY && !internal_osc_stable_flag_o);
	endproperty
	a_switch: assert property (p_switch) else $error("no switch to primary");
	property p_wdt_rst;
		wdt_reset_o |-> ##[0:1] (cpu_reset_hold_o
			&& oscillator_control_reg_o == lpws_pkg::OSC_CTRL_RST);
	endproperty
	a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog reset bad");
	property p_trim;
		osc_tune_wr_i |=> fast_osc_trim_o == $past(osc_tune_wdata_i)
			&& slow_rc_trim_o == fast_osc_trim_o;
	endproperty
	a_trim: assert property (p_trim) else $error("trim mismatch");
	property p_freq_clr;
		osc_ctrl_wr_i && cpu_run_o && sys_clk_sel_o == lpws_pkg::CLK_INTERNAL
			&& osc_ctrl_wdata_i[6:4] != oscillator_control_reg_o[6:4]
			|=> wdt_clear_o;
	endproperty
	a_freq_clr: assert property (p_freq_clr) else $error("no clear on freq");
endmodule
bind lpws_wake_seq lpws_checker lpws_checker_inst (.clk_i, .rst_i,
	.primary_mode_i, .dual_speed_startup_i, .clock_fail_monitor_i,
	.sleep_instr_i, .watchdog_clear_instruction_i, .interrupt_control_reg_i,
	.osc_ctrl_wr_i, .osc_ctrl_wdata_i, .osc_tune_wr_i, .osc_tune_wdata_i,
	.cpu_run_o, .cpu_reset_hold_o, .wake_vector_o, .wake_resume_o,
	.sys_clk_sel_o, .primary_osc_en_o, .primary_clock_ready_flag_o,
	.internal_osc_stable_flag_o, .oscillator_control_reg_o,
	.fast_osc_trim_o, .slow_rc_trim_o, .wdt_clear_o, .wdt_reset_o);

// >>> testbench/lpws_partner.sv
/*
 * Far side model: crystal pin, interrupt flags and watchdog time-out.
 * Assumes the bench commands flags and time-outs; all outputs are async.
 */
`timescale 1ns/10ps
module lpws_partner (
	// Oscillator control
	input wire logic osc_en_i,
	// Commands from the bench
	input wire logic [7:0] irq_set_i,
	input wire logic wdt_fire_i,
	// Far side signals
	output logic primary_osc_o,
	output logic [7:0] irq_flag_o,
	output logic wdt_timeout_o
);
	initial primary_osc_o = 1'b0;
	// Unrelated to clk_i; a stopped crystal rests low
	always begin
		#17;
		primary_osc_o = osc_en_i ? ~primary_osc_o : 1'b0;
	end
	// Off-grid arrival exercises the synchronisers
	assign #3 irq_flag_o = irq_set_i;
	assign #3 wdt_timeout_o = wdt_fire_i;
endmodule

// >>> testbench/tb_low_power_wake_sequencer.sv
/*
 * Self-checking bench for the wake sequencer with a far side model.
 * Assumes the bound checker; restart results go through a queue.
 */
`timescale 1ns/10ps
module tb_low_power_wake_sequencer;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	lpws_pkg::lpws_pri_t primary_mode_i = lpws_pkg::PRI_CRYSTAL_PLL_MODE;
	logic dual_speed_startup_i = 1'b0;
	logic clock_fail_monitor_i = 1'b0;
	logic sleep_instr_i = 1'b0;
	logic idle_en_i = 1'b0;
	logic watchdog_clear_instruction_i = 1'b0;
	logic [7:0] interrupt_control_reg_i = 8'h00;
	logic osc_ctrl_wr_i = 1'b0;
	logic [7:0] osc_ctrl_wdata_i = 8'h00;
	logic osc_tune_wr_i = 1'b0;
	logic [5:0] osc_tune_wdata_i = 6'h00;
	logic [7:0] irq_enable_i = 8'h00;
	logic [7:0] irq_set = 8'h00;
	logic wdt_fire = 1'b0;
	logic reset_req_i = 1'b0;
	logic clock_loss_i = 1'b0;
	logic [7:0] irq_flag_i;
	logic wdt_timeout_i, primary_osc_i, cpu_run_o, cpu_reset_hold_o;
	logic wake_vector_o, wake_resume_o, primary_osc_en_o;
	logic primary_clock_ready_flag_o, internal_osc_stable_flag_o;
	logic wdt_clear_o, wdt_reset_o;
	lpws_pkg::lpws_clk_t sys_clk_sel_o;
	logic [7:0] oscillator_control_reg_o;
	logic [5:0] fast_osc_trim_o, slow_rc_trim_o;
	logic [2:0] exp_q[$];
	int errors = 0;
	int checks_done = 0;
	int n;
	int src;
	always #5 clk_i = ~clk_i;
	lpws_wake_seq #(.OST_EDGES(4), .PLL_CYC(20), .IOS_CYC(30))
		lpws_wake_seq_inst (.clk_i, .rst_i, .primary_mode_i,
		.dual_speed_startup_i, .clock_fail_monitor_i, .sleep_instr_i,
		.idle_en_i, .watchdog_clear_instruction_i, .interrupt_control_reg_i,
		.osc_ctrl_wr_i, .osc_ctrl_wdata_i, .osc_tune_wr_i, .osc_tune_wdata_i,
		.irq_flag_i, .irq_enable_i, .wdt_timeout_i, .reset_req_i,
		.clock_loss_i, .primary_osc_i, .cpu_run_o, .cpu_reset_hold_o,
		.wake_vector_o, .wake_resume_o, .sys_clk_sel_o, .primary_osc_en_o,
		.primary_clock_ready_flag_o, .internal_osc_stable_flag_o,
		.oscillator_control_reg_o, .fast_osc_trim_o, .slow_rc_trim_o,
		.wdt_clear_o, .wdt_reset_o);
	lpws_partner lpws_partner_inst (.osc_en_i(primary_osc_en_o),
		.irq_set_i(irq_set), .wdt_fire_i(wdt_fire),
		.primary_osc_o(primary_osc_i), .irq_flag_o(irq_flag_i),
		.wdt_timeout_o(wdt_timeout_i));
	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask
	task automatic wait_run(output int cyc);
		cyc = 0;
		while (cpu_run_o !== 1'b1 && cyc < 5000) begin
			step(1);
			cyc++;
		end
		if (cyc >= 5000)
			errors++;
	endtask
	task automatic do_sleep(input logic idle);
		idle_en_i = idle;
		sleep_instr_i = 1'b1;
		step(1);
		sleep_instr_i = 1'b0;
		chk("sleep clear", 8'h01, {7'h00, wdt_clear_o});
		chk("halted", 8'h00, {7'h00, cpu_run_o});
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Oldest restart note against each restart seen
	// Falling edge, so the pulse is seen settled and exactly once
	always @(negedge clk_i) begin
		if (wake_vector_o || wake_resume_o || wdt_reset_o) begin
			chk("restart", {5'h00, exp_q.size() > 0 ? exp_q.pop_front() : 3'h0},
				{5'h00, wdt_reset_o, wake_vector_o, wake_resume_o});
		end
	end
	initial begin
		#400000;
		errors++;
		stop_test();
	end
	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		void'($urandom(32'ha368f620));
		repeat (5) @(posedge clk_i);
		#1;
		chk("rst hold", 8'h01, {7'h00, cpu_reset_hold_o});
		chk("rst ctrl", 8'h00, oscillator_control_reg_o);
		chk("rst clk", {6'h00, lpws_pkg::CLK_INTERNAL}, {6'h00, sys_clk_sel_o});
		rst_i = 1'b0;
		reset_req_i = 1'b1;
		step(60);
		chk("req hold", 8'h01, {7'h00, cpu_reset_hold_o});
		reset_req_i = 1'b0;
		wait_run(n);
		chk("ready", 8'h01, {7'h00, primary_clock_ready_flag_o});
		step(3);
		chk("clk", {6'h00, lpws_pkg::CLK_PRIMARY}, {6'h00, sys_clk_sel_o});
		for (int k = 0; k < 4; k++) begin
			src = $urandom_range(7, 0);
			irq_enable_i = 8'h01 << src;
			interrupt_control_reg_i = {k[0], 7'h00};
			do_sleep(k[1]);
			irq_set = ~irq_enable_i;
			step(50);
			chk("masked", 8'h00, {7'h00, cpu_run_o});
			exp_q.push_back(k[0] ? 3'b010 : 3'b001);
			irq_set = 8'hff;
			wait_run(n);
			chk("prep", 8'h01, {7'h00, n >= 1000});
			irq_set = 8'h00;
			// Let the synced flag fall before the next sleep
			step(6);
			chk("woke ready", 8'h01, {7'h00, primary_clock_ready_flag_o});
		end
		do_sleep(1'b0);
		exp_q.push_back(3'b001);
		wdt_fire = 1'b1;
		step(8);
		wdt_fire = 1'b0;
		wait_run(n);
		exp_q.push_back(3'b100);
		wdt_fire = 1'b1;
		step(8);
		wdt_fire = 1'b0;
		chk("wdt hold", 8'h01, {7'h00, cpu_reset_hold_o});
		wait_run(n);
		watchdog_clear_instruction_i = 1'b1;
		step(1);
		watchdog_clear_instruction_i = 1'b0;
		chk("clr", 8'h01, {7'h00, wdt_clear_o});
		clock_fail_monitor_i = 1'b1;
		clock_loss_i = 1'b1;
		step(6);
		chk("loss clr", 8'h01, {7'h00, wdt_clear_o});
		clock_loss_i = 1'b0;
		clock_fail_monitor_i = 1'b0;
		step(6);
		chk("loss gone", 8'h00, {7'h00, wdt_clear_o});
		osc_tune_wdata_i = 6'($urandom);
		osc_tune_wr_i = 1'b1;
		step(1);
		osc_tune_wr_i = 1'b0;
		chk("trim", {2'h0, osc_tune_wdata_i}, {2'h0, slow_rc_trim_o});
		dual_speed_startup_i = 1'b1;
		rst_i = 1'b1;
		step(2);
		rst_i = 1'b0;
		wait_run(n);
		chk("early rdy", 8'h00, {7'h00, primary_clock_ready_flag_o});
		osc_ctrl_wdata_i = {1'b0, 3'($urandom_range(7, 1)), 4'h0};
		osc_ctrl_wr_i = 1'b1;
		step(1);
		osc_ctrl_wr_i = 1'b0;
		chk("freq clr", 8'h01, {7'h00, wdt_clear_o});
		do_sleep(1'b0);
		step(1);
		chk("pri off", 8'h00, {7'h00, primary_osc_en_o});
		irq_enable_i = 8'h01;
		interrupt_control_reg_i = 8'h00;
		exp_q.push_back(3'b001);
		irq_set = 8'h01;
		wait_run(n);
		irq_set = 8'h00;
		step(100);
		chk("late clk", {6'h00, lpws_pkg::CLK_PRIMARY}, {6'h00, sys_clk_sel_o});
		chk("pending", 8'h00, 8'(exp_q.size()));
		stop_test();
	end
endmodule
